// *** design/gpd_regs.svh ***
// constants of the planar graphics datapath: port addresses, indexes, fields
// assumes an 8-bit host i/o port pair (index port, data port) on one clock
`ifndef GPD_REGS_SVH
`define GPD_REGS_SVH
// ****************************************
// i/o port addresses
// ****************************************
`define GPD_PORT_INDEX 16'h03ce
`define GPD_PORT_DATA 16'h03cf
// ****************************************
// indexed register numbers
// ****************************************
`define GPD_IDX_SET_RESET 4'h0
`define GPD_IDX_SR_ENABLE 4'h1
`define GPD_IDX_COLOR_CMP 4'h2
`define GPD_IDX_ROTATE_FN 4'h3
`define GPD_IDX_READ_PLANE 4'h4
`define GPD_IDX_MODE 4'h5
`define GPD_IDX_MISC 4'h6
`define GPD_IDX_CARE 4'h7
`define GPD_IDX_BIT_MASK 4'h8
// ****************************************
// field positions
// ****************************************
`define GPD_ROT_LSB 0
`define GPD_ROT_MSB 2
`define GPD_FN_LSB 3
`define GPD_FN_MSB 4
`define GPD_MODE_WM_LSB 0
`define GPD_MODE_WM_MSB 1
`define GPD_MODE_RM_BIT 3
`define GPD_MODE_OE_BIT 4
`define GPD_MODE_256_BIT 6
`define GPD_MISC_GFX_BIT 0
`define GPD_MISC_OE_BIT 1
`define GPD_MISC_MAP_LSB 2
`define GPD_MISC_MAP_MSB 3
// ****************************************
// reset values (none documented, all clear)
// ****************************************
`define GPD_RST_BYTE 8'h00
`endif

// *** design/gpd_pkg.sv ***
// types of the planar graphics datapath
// assumes four display planes of one byte each per address
package gpd_pkg;
  // write modes held in the mode register
  typedef enum logic [1:0] {
    GPD_WM0 = 2'b00,
    GPD_WM1 = 2'b01,
    GPD_WM2 = 2'b10,
    GPD_WM3 = 2'b11
  } gpd_wmode_t;
  // logic unit operations
  typedef enum logic [1:0] {
    GPD_FN_MOVE = 2'b00,
    GPD_FN_AND = 2'b01,
    GPD_FN_OR = 2'b10,
    GPD_FN_XOR = 2'b11
  } gpd_func_t;
  // one byte for each plane
  typedef logic [3:0][7:0] gpd_planes_t;
  // a host i/o access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } gpd_io_req_t;
endpackage : gpd_pkg

// *** design/gpd_datapath.sv ***
// planar write/read datapath of the graphics data controller
// assumes host i/o and memory requests are synchronous to ref_clk and
// that display memory answers a read in the cycle its strobe stands
`timescale 1ns/1ns
`include "gpd_regs.svh"
module gpd_datapath
  import gpd_pkg::*;
#(
  parameter int AW = 16 // cpu/display address width
) (
  input wire logic ref_clk, // 20 mhz host bus clock
  input wire logic rst, // async reset, active high
  input wire gpd_io_req_t io_req, // host i/o access
  output logic [7:0] io_rdata_q, // i/o read data
  output logic io_rvalid_q, // i/o read data valid pulse
  input wire logic mem_wr, // cpu display memory write pulse
  input wire logic mem_rd, // cpu display memory read pulse
  input wire logic [AW-1:0] cpu_addr, // cpu memory address
  input wire logic [7:0] cpu_wdata, // cpu memory write data
  input wire logic [3:0] plane_wr_en, // plane write selection from sequencer
  output logic mem_ready, // may take a memory request
  output logic [7:0] cpu_rdata_q, // memory read data to cpu
  output logic cpu_rvalid_q, // memory read data valid pulse
  output logic [AW-1:0] dm_addr_q, // display memory address
  output logic [3:0] dm_we_q, // display memory plane write strobes
  output logic dm_re_q, // display memory read strobe
  output gpd_planes_t dm_wdata_q, // display memory write data
  input wire gpd_planes_t dm_rdata, // display memory read data
  output logic gfx_mode, // graphics (1) or text (0) mode
  output logic [1:0] mem_map_sel, // frame buffer mapping select
  output logic color256_en // 256 color shift load select
);

  // ****************************************
  // indexed register file
  // ****************************************
  logic [3:0] index_q; // selected indexed register
  logic [3:0] set_reset_q; // set/reset value per plane
  logic [3:0] sr_enable_q; // set/reset enable per plane
  logic [3:0] color_cmp_q; // compare color
  logic [4:0] rotate_fn_q; // function select and rotate count
  logic [1:0] read_plane_q; // read plane select
  logic [7:0] mode_q; // mode register, reserved bits held zero
  logic [3:0] misc_q; // memory map, odd/even, graphics enable
  logic [3:0] care_q; // compare participation mask
  logic [7:0] bit_mask_q; // per-bit write mask
  logic data_sel; // i/o access hits the data port
  logic index_sel; // i/o access hits the index port

  assign index_sel = (io_req.addr == `GPD_PORT_INDEX);
  assign data_sel = (io_req.addr == `GPD_PORT_DATA);

  // index port write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      index_q <= 4'h0;
    end else if (io_req.wr && index_sel) begin
      index_q <= io_req.wdata[3:0];
    end
  end

  // data port writes; reserved bits never stored so they read as zero
  // a new setting applies from the next edge, so a memory request taken
  // in the same cycle as the data write still sees the old setting, except that a read uses the new compare color and care mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      set_reset_q <= 4'h0;
      sr_enable_q <= 4'h0;
      color_cmp_q <= 4'h0;
      rotate_fn_q <= 5'h00;
      read_plane_q <= 2'h0;
      mode_q <= `GPD_RST_BYTE;
      misc_q <= 4'h0;
      care_q <= 4'h0;
      bit_mask_q <= `GPD_RST_BYTE;
    end else if (io_req.wr && data_sel) begin
      unique case (index_q)
        `GPD_IDX_SET_RESET: begin
          set_reset_q <= io_req.wdata[3:0];
        end
        `GPD_IDX_SR_ENABLE: begin
          sr_enable_q <= io_req.wdata[3:0];
        end
        `GPD_IDX_COLOR_CMP: begin
          color_cmp_q <= io_req.wdata[3:0];
        end
        `GPD_IDX_ROTATE_FN: begin
          rotate_fn_q <= io_req.wdata[4:0];
        end
        `GPD_IDX_READ_PLANE: begin
          read_plane_q <= io_req.wdata[1:0];
        end
        `GPD_IDX_MODE: begin
          mode_q <= io_req.wdata & 8'h5b;
        end
        `GPD_IDX_MISC: begin
          misc_q <= io_req.wdata[3:0];
        end
        `GPD_IDX_CARE: begin
          care_q <= io_req.wdata[3:0];
        end
        `GPD_IDX_BIT_MASK: begin
          bit_mask_q <= io_req.wdata;
        end
        // unknown indexes are written nowhere
        default: begin
        end
      endcase
    end
  end

  // register readback value for the current index
  function automatic logic [7:0] gpd_reg_read(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `GPD_IDX_SET_RESET: v = {4'h0, set_reset_q};
      `GPD_IDX_SR_ENABLE: v = {4'h0, sr_enable_q};
      `GPD_IDX_COLOR_CMP: v = {4'h0, color_cmp_q};
      `GPD_IDX_ROTATE_FN: v = {3'h0, rotate_fn_q};
      `GPD_IDX_READ_PLANE: v = {6'h00, read_plane_q};
      `GPD_IDX_MODE: v = mode_q;
      `GPD_IDX_MISC: v = {4'h0, misc_q};
      `GPD_IDX_CARE: v = {4'h0, care_q};
      `GPD_IDX_BIT_MASK: v = bit_mask_q;
      // unmapped indexes read zero
      default: v = 8'h00;
    endcase
    return v;
  endfunction : gpd_reg_read

  // i/o read answer, one cycle after the request; other ports read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_rdata_q <= 8'h00;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= io_req.rd;
      if (io_req.rd) begin
        if (index_sel) begin
          io_rdata_q <= {4'h0, index_q};
        end else if (data_sel) begin
          io_rdata_q <= gpd_reg_read(index_q);
        end else begin
          io_rdata_q <= 8'h00;
        end
      end
    end
  end

  // ****************************************
  // mode decode
  // ****************************************
  gpd_wmode_t wmode; // current write mode
  gpd_func_t func; // current logic operation
  logic [2:0] rot_cnt; // rotate count
  logic odd_even; // odd/even chaining active

  assign wmode = gpd_wmode_t'(mode_q[`GPD_MODE_WM_MSB:`GPD_MODE_WM_LSB]);
  assign func = gpd_func_t'(rotate_fn_q[`GPD_FN_MSB:`GPD_FN_LSB]);
  assign rot_cnt = rotate_fn_q[`GPD_ROT_MSB:`GPD_ROT_LSB];
  assign odd_even = misc_q[`GPD_MISC_OE_BIT];
  assign gfx_mode = misc_q[`GPD_MISC_GFX_BIT];
  assign mem_map_sel = misc_q[`GPD_MISC_MAP_MSB:`GPD_MISC_MAP_LSB];
  assign color256_en = mode_q[`GPD_MODE_256_BIT];

  // ****************************************
  // write datapath
  // ****************************************
  gpd_planes_t latch_q; // one latch per plane
  gpd_planes_t wr_data; // next byte for each plane
  logic [7:0] rot_data; // rotated cpu data
  logic [7:0] eff_mask; // effective per-bit mask
  logic [15:0] rot_dbl; // doubled byte for a circular shift

  // rotate right, bit 0 wraps to bit 7; done before any masking
  assign rot_dbl = {cpu_wdata, cpu_wdata} >> rot_cnt;
  assign rot_data = rot_dbl[7:0];

  // mode 3 uses rotated data and mask as its mask, others the plain mask
  assign eff_mask = (wmode == GPD_WM3) ? (rot_data & bit_mask_q) : bit_mask_q;

  // logic unit between processed data and latch
  function automatic logic [7:0] gpd_alu(input gpd_func_t f, input logic [7:0] d,
                                         input logic [7:0] l);
    logic [7:0] r;
    r = d;
    unique case (f)
      GPD_FN_MOVE: r = d;
      GPD_FN_AND: r = d & l;
      GPD_FN_OR: r = d | l;
      GPD_FN_XOR: r = d ^ l;
    endcase
    return r;
  endfunction : gpd_alu

  // per-plane data path, identical for all four planes
  for (genvar p = 0; p < 4; p++) begin : g_plane
    logic [7:0] src; // processed cpu data for this plane
    always_comb begin
      src = rot_data;
      unique case (wmode)
        GPD_WM0: begin
          src = sr_enable_q[p] ? {8{set_reset_q[p]}} : rot_data;
        end
        GPD_WM2: begin
          // no rotation here: the raw cpu bit is replicated
          src = sr_enable_q[p] ? {8{set_reset_q[p]}} : {8{cpu_wdata[p]}};
        end
        GPD_WM3: begin
          src = {8{set_reset_q[p]}};
        end
        GPD_WM1: begin
          src = latch_q[p];
        end
      endcase
      if (wmode == GPD_WM1) begin
        wr_data[p] = latch_q[p];
      end else begin
        // mask 1 passes the alu result, 0 keeps the latched bit
        wr_data[p] = (gpd_alu(func, src, latch_q[p]) & eff_mask)
                     | (latch_q[p] & ~eff_mask);
      end
    end
  end

  // ****************************************
  // address and plane selection
  // ****************************************
  logic [AW-1:0] mem_addr; // display address after odd/even swap
  logic [3:0] oe_planes; // planes reachable under odd/even
  logic [3:0] wr_planes; // planes written by this access

  // odd/even puts a high-order bit in place of address bit 0
  // limitation: the top cpu address bit stands in for bit 0, so each even/odd
  // address pair lands on one display location while chaining is on
  assign mem_addr = odd_even ? {cpu_addr[AW-1:1], cpu_addr[AW-1]} : cpu_addr;
  // even planes on even addresses, odd planes on odd addresses
  assign oe_planes = cpu_addr[0] ? 4'b1010 : 4'b0101;
  assign wr_planes = (wmode == GPD_WM1) ? 4'hf
                     : (plane_wr_en & (odd_even ? oe_planes : 4'hf));

  // ****************************************
  // memory access sequencer
  // ****************************************
  typedef enum logic [0:0] {
    GPD_ST_IDLE,
    GPD_ST_READ
  } gpd_state_t;
  gpd_state_t state_q; // access state
  logic [1:0] rd_plane_q; // plane for a mode 0 read
  logic rd_mode_q; // read mode captured with the request

  // one access at a time; a read holds the port for its data cycle
  // trade-off: one busy cycle per read keeps the memory port free of queues
  assign mem_ready = (state_q == GPD_ST_IDLE);

  // state and request capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= GPD_ST_IDLE;
      rd_plane_q <= 2'h0;
      rd_mode_q <= 1'b0;
    end else begin
      unique case (state_q)
        GPD_ST_IDLE: begin
          if (mem_rd && !mem_wr) begin
            state_q <= GPD_ST_READ;
            rd_mode_q <= mode_q[`GPD_MODE_RM_BIT];
            // odd/even reads pick the pair member by the low address bit
            rd_plane_q <= (mode_q[`GPD_MODE_OE_BIT] || odd_even)
                          ? {read_plane_q[1], cpu_addr[0]} : read_plane_q;
          end
        end
        GPD_ST_READ: begin
          state_q <= GPD_ST_IDLE;
        end
      endcase
    end
  end

  // display memory strobes, address and data come from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dm_addr_q <= '0;
      dm_we_q <= 4'h0;
      dm_re_q <= 1'b0;
      dm_wdata_q <= '0;
    end else begin
      dm_we_q <= 4'h0;
      dm_re_q <= 1'b0;
      if (mem_ready && mem_wr) begin
        dm_addr_q <= mem_addr;
        dm_we_q <= wr_planes;
        dm_wdata_q <= wr_data;
      end else if (mem_ready && mem_rd) begin
        dm_addr_q <= mem_addr;
        dm_re_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // read path and latches
  // ****************************************
  logic [7:0] cmp_result; // read mode 1 pixel match bits

  // a pixel matches when every cared plane equals its compare bit
  // with no plane cared for, every pixel matches and the result is all ones
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cmp_result[i] = 1'b1;
      for (int p = 0; p < 4; p++) begin
        if (care_q[p] && (dm_rdata[p][i] != color_cmp_q[p])) begin
          cmp_result[i] = 1'b0;
        end
      end
    end
  end

  // latches load from all planes on every memory read
  // a mode 1 copy writes what the last read left here, so software must
  // read the source location before each copying write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_q <= '0;
    end else if (state_q == GPD_ST_READ) begin
      latch_q <= dm_rdata;
    end
  end

  // read answer to the cpu
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata_q <= 8'h00;
      cpu_rvalid_q <= 1'b0;
    end else begin
      cpu_rvalid_q <= (state_q == GPD_ST_READ);
      if (state_q == GPD_ST_READ) begin
        cpu_rdata_q <= rd_mode_q ? cmp_result
                       : dm_rdata[rd_plane_q];
      end
    end
  end

endmodule : gpd_datapath

// *** test/gpd_mem_model.sv ***
// display memory model: four planes, 64 locations
// assumes combinational read data while dm_re_q stands
`timescale 1ns/1ns
module gpd_mem_model
  import gpd_pkg::*;
#(
  parameter int AW = 16 // address width
) (
  input wire logic ref_clk, // clock
  input wire logic [AW-1:0] dm_addr_q, // address
  input wire logic [3:0] dm_we_q, // plane strobes
  input wire logic dm_re_q, // read strobe
  input wire gpd_planes_t dm_wdata_q, // write data
  output gpd_planes_t dm_rdata // read data
);
  gpd_planes_t mem [0:63]; // low address bits only, aliases above
  gpd_planes_t last_q; // last value handed out
  initial begin
    last_q = '0;
    for (int i = 0; i < 64; i++) mem[i] = '0;
  end
  // plane writes and read history
  always @(posedge ref_clk) begin
    for (int p = 0; p < 4; p++) if (dm_we_q[p]) mem[dm_addr_q[5:0]][p] <= dm_wdata_q[p];
    if (dm_re_q) last_q <= mem[dm_addr_q[5:0]];
  end
  // undriven bus shows inverse, so stale data never matches by luck
  assign dm_rdata = dm_re_q ? mem[dm_addr_q[5:0]] : ~last_q;
endmodule : gpd_mem_model

// *** test/gpd_datapath_checker.sv ***
// port checker for the planar datapath, bound to its top module
// assumes registers change only through the i/o port pair
`timescale 1ns/1ns
`include "gpd_regs.svh"
module gpd_datapath_checker
  import gpd_pkg::*;
#(
  parameter int AW = 16 // address width
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire gpd_io_req_t io_req, // i/o access
  input wire logic mem_wr, // write request
  input wire logic mem_rd, // read request
  input wire logic [AW-1:0] cpu_addr, // cpu address
  input wire logic mem_ready, // request accept
  input wire logic [7:0] cpu_rdata_q, // read result
  input wire logic cpu_rvalid_q, // result valid
  input wire logic [AW-1:0] dm_addr_q, // memory address
  input wire logic [3:0] dm_we_q, // plane strobes
  input wire logic dm_re_q, // read strobe
  input wire gpd_planes_t dm_wdata_q, // write data
  input wire gpd_planes_t dm_rdata, // read data
  input wire logic gfx_mode, // graphics mode
  input wire logic [1:0] mem_map_sel // map select
);
  // *****
  // shadow state
  // *****
  logic [3:0] idx_q; // shadow index
  logic [7:0] regs_q [0:8]; // shadow registers
  gpd_planes_t lat_q; // shadow latches
  logic misc_wr, wr_take, rd_take, oe; // helpers
  assign misc_wr = io_req.wr && io_req.addr == `GPD_PORT_DATA && idx_q == `GPD_IDX_MISC;
  assign wr_take = mem_wr && mem_ready;
  assign rd_take = mem_rd && !mem_wr && mem_ready;
  assign oe = regs_q[5][4] | regs_q[6][1];
  // index and data port shadows
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idx_q <= '0;
      for (int i = 0; i < 9; i++) regs_q[i] <= '0;
    end else if (io_req.wr && io_req.addr == `GPD_PORT_INDEX) begin
      idx_q <= io_req.wdata[3:0];
    end else if (io_req.wr && io_req.addr == `GPD_PORT_DATA && idx_q < 4'h9) begin
      regs_q[idx_q] <= io_req.wdata;
    end
  end
  // latches follow memory read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) lat_q <= '0;
    else if (dm_re_q) lat_q <= dm_rdata;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_strobe: assert property (rd_take |=> dm_re_q && !mem_ready)
    else $error("read strobe missing");
  a_read_answer: assert property (dm_re_q |=> cpu_rvalid_q ##1 !cpu_rvalid_q)
    else $error("read answer not one pulse");
  a_write_addr: assert property ((wr_take || rd_take) && !oe |=>
    dm_addr_q == $past(cpu_addr))
    else $error("address altered without odd/even");
  a_oe_addr: assert property ((wr_take || rd_take) && regs_q[6][1] |=>
    dm_addr_q == $past({cpu_addr[AW-1:1], cpu_addr[AW-1]}))
    else $error("odd/even address bit 0 not replaced");
  a_oe_planes: assert property (wr_take && regs_q[6][1] && regs_q[5][1:0] != 2'b01 |=>
    (dm_we_q & ($past(cpu_addr[0]) ? 4'b0101 : 4'b1010)) == 4'h0)
    else $error("odd/even write reached a plane of the other parity");
  a_wm1_planes: assert property (wr_take && regs_q[5][1:0] == 2'b01 |=> dm_we_q == 4'hf)
    else $error("copy write not to all planes");
  a_wm1_data: assert property (wr_take && regs_q[5][1:0] == 2'b01 |=>
    dm_wdata_q == $past(lat_q))
    else $error("copy write data differs from latches");
  a_misc_gfx: assert property (misc_wr |=> gfx_mode == $past(io_req.wdata[0]))
    else $error("graphics mode not from misc bit 0");
  a_misc_map: assert property (misc_wr |=> mem_map_sel == $past(io_req.wdata[3:2]))
    else $error("map select not from misc bits 3:2");
  a_care_none: assert property (rd_take && regs_q[5][3] && regs_q[7][3:0] == 4'h0
    |-> ##2 cpu_rvalid_q && cpu_rdata_q == 8'hff)
    else $error("compare without care not all ones");
  c_copy: cover property (wr_take && regs_q[5][1:0] == 2'b01);
  c_compare: cover property (rd_take && regs_q[5][3]);
  c_misc: cover property (misc_wr);
  c_odd_even: cover property (wr_take && regs_q[6][1]);
endmodule : gpd_datapath_checker
bind gpd_datapath gpd_datapath_checker #(.AW(AW)) u_chk (.*);

// *** test/gpd_datapath_tb.sv ***
// self-checking bench of the planar datapath with a memory model
// assumes the datapath answers as its hand-over contract says
`timescale 1ns/1ns
`include "gpd_regs.svh"
module gpd_datapath_tb;
  import gpd_pkg::*;
  logic ref_clk, rst, mem_wr, mem_rd, mem_ready, io_rvalid_q, cpu_rvalid_q, dm_re_q; // wires
  logic gfx_mode, color256_en; // mode outputs
  logic [1:0] mem_map_sel; // map select
  logic [7:0] io_rdata_q, cpu_rdata_q, cpu_wdata; // data bytes
  logic [15:0] cpu_addr, dm_addr_q; // addresses
  logic [3:0] plane_wr_en, dm_we_q; // plane selects
  gpd_io_req_t io_req; // i/o access
  gpd_planes_t dm_wdata_q, dm_rdata, ref_l; // plane data, expected latches
  gpd_planes_t ref_m [0:63]; // expected memory
  logic [7:0] r [0:8]; // expected registers
  logic [7:0] mq[$], iq[$]; // pending expected read results
  int fail_count, n_compared; // tallies
  // readable bits of indexes 0..9, unmapped index reads zero
  localparam logic [7:0] MSK [0:9] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h5b, 8'h0f,
    8'h0f, 8'hff, 8'h00};
  gpd_datapath u_gpd_datapath (.*);
  gpd_mem_model u_gpd_mem_model (.*);
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  // *****
  // tasks
  // *****
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task stop_test;
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    io_req = '{w, !w, a, d};
    @(posedge ref_clk);
    #2;
    io_req = '0;
  endtask : io
  task setreg(input int i, input logic [7:0] v);
    r[i] = v;
    io(1, `GPD_PORT_INDEX, 8'(i));
    io(1, `GPD_PORT_DATA, v);
  endtask : setreg
  task mem(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [3:0] pe);
    @(posedge ref_clk);
    #2;
    repeat (4) if (mem_ready !== 1'b1) begin
      @(posedge ref_clk);
      #2;
    end
    {mem_wr, mem_rd, cpu_addr, cpu_wdata, plane_wr_en} = {w, !w, a, d, pe};
    @(posedge ref_clk);
    #2;
    {mem_wr, mem_rd} = 2'b00;
  endtask : mem
  task mwr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] pe);
    logic [7:0] rd, v, m;
    logic [5:0] ea;
    logic [3:0] pm;
    ea = r[6][1] ? {a[5:1], a[15]} : a[5:0];
    pm = pe & (r[6][1] ? (a[0] ? 4'b1010 : 4'b0101) : 4'hf);
    rd = 8'({d, d} >> r[3][2:0]);
    m = (r[5][1:0] == 2'd3) ? rd & r[8] : r[8];
    for (int p = 0; p < 4; p++) begin
      case (r[5][1:0])
        2'd0: v = r[1][p] ? {8{r[0][p]}} : rd;
        2'd2: v = r[1][p] ? {8{r[0][p]}} : {8{d[p]}};
        default: v = {8{r[0][p]}};
      endcase
      case (r[3][4:3])
        2'd1: v = v & ref_l[p];
        2'd2: v = v | ref_l[p];
        2'd3: v = v ^ ref_l[p];
        default: v = v;
      endcase
      if (r[5][1:0] == 2'd1) ref_m[ea][p] = ref_l[p];
      else if (pm[p]) ref_m[ea][p] = (v & m) | (ref_l[p] & ~m);
    end
    mem(1, a, d, pe);
  endtask : mwr
  task mrd(input logic [15:0] a);
    logic [7:0] e;
    logic [5:0] ea;
    gpd_planes_t q;
    ea = r[6][1] ? {a[5:1], a[15]} : a[5:0];
    q = ref_m[ea];
    for (int i = 0; i < 8; i++) e[i] = ((r[2][3:0] ^ {q[3][i], q[2][i], q[1][i], q[0][i]})
      & r[7][3:0]) == 4'h0;
    if (!r[5][3]) e = q[(r[5][4] | r[6][1]) ? {r[4][1], a[0]} : r[4][1:0]];
    ref_l = q;
    mq.push_back(e);
    mem(0, a, 8'h00, 4'h0);
  endtask : mrd
  // result watchers take the oldest note when data is valid
  always @(posedge ref_clk) begin
    if (cpu_rvalid_q === 1'b1) chk(cpu_rdata_q, mq.size() ? mq.pop_front() : ~cpu_rdata_q);
    if (io_rvalid_q === 1'b1) chk(io_rdata_q, iq.size() ? iq.pop_front() : ~io_rdata_q);
  end
  // hang guard, about twice the expected run
  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end
  // *****
  // main sequence
  // *****
  initial begin
    logic [15:0] a;
    void'($urandom(32'h6211));
    rst = 1;
    io_req = '0;
    {mem_wr, mem_rd, cpu_addr, cpu_wdata, plane_wr_en} = '0;
    ref_l = '0;
    for (int i = 0; i < 64; i++) ref_m[i] = '0;
    for (int i = 0; i < 9; i++) r[i] = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (12) @(posedge ref_clk);
    #2;
    rst = 0;
    chk({gfx_mode, mem_map_sel, color256_en, mem_ready}, 8'h01);
    // set every bit of each index and read back the kept ones
    for (int i = 0; i < 10; i++) begin
      io(1, `GPD_PORT_INDEX, 8'(i));
      io(1, `GPD_PORT_DATA, 8'hff);
      iq.push_back(MSK[i]);
      io(0, `GPD_PORT_DATA, 8'h00);
    end
    chk({gfx_mode, mem_map_sel, color256_en}, 8'h0f);
    // every write mode and logic function, random operands, odd/even on and off
    for (int n = 0; n < 320; n++) begin
      for (int i = 0; i < 9; i++) setreg(i, 8'($urandom) & MSK[i]);
      setreg(3, {3'b000, 2'(n >> 2), 3'($urandom)});
      setreg(5, {3'h0, 1'($urandom), 1'($urandom), 1'b0, 2'(n)});
      setreg(6, 8'($urandom) & 8'h0f);
      a = 16'($urandom);
      mwr(a, 8'($urandom), 4'($urandom));
      mwr(a ^ 16'h0001, 8'($urandom), 4'($urandom));
      mrd(a);
      mrd(16'($urandom));
    end
    repeat (4) @(posedge ref_clk);
    chk(8'(mq.size() + iq.size()), 8'h00);
    stop_test();
  end
endmodule : gpd_datapath_tb
